// >>> rtl/sla_top.sv
// sla_top: sync loss delay alarm with relay drive and setup menu
`timescale 1ns/1ps
`default_nettype none
//
// Function
// R1: two-digit decimal delay, 00 to 99 minutes
// R2: alarm only after continuous loss for delay
// R3: relay follows alarm in same cycle
// R4: delay 00 keeps both outputs locked
// R5: relay energized while locked, off when faulted
// R6: setup key walks menu; enter opens delay
// R7: up/down edit candidate; enter stores, returns
// R8: top-row function key leaves setup menu
// R9: count unlocked minutes; clear on lock; hold
module sla_top (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   // status inputs
   input  wire logic       i_sync_locked,
   input  wire logic       i_sec_tick,
   // key presses, one-cycle pulses
   input  wire logic       i_key_setup,
   input  wire logic       i_key_up,
   input  wire logic       i_key_down,
   input  wire logic       i_key_enter,
   input  wire logic       i_key_func,
   // alarm outputs
   output logic            o_sync_loss_alarm,
   output logic            o_relay_energize,
   // display view
   output logic            o_menu_active,
   output logic      [1:0] o_menu_item,
   output logic            o_edit_active,
   output logic      [3:0] o_disp_tens,
   output logic      [3:0] o_disp_ones
);
   // ***************************************************
   // state
   // ***************************************************
   sla_pkg::sla_menu_t menu_ff;
   logic [1:0]         item_ff;
   logic [3:0]         set_tens_ff;
   logic [3:0]         set_ones_ff;
   logic [3:0]         cand_tens_ff;
   logic [3:0]         cand_ones_ff;
   logic [3:0]         step_tens;
   logic [3:0]         step_ones;
   logic [5:0]         sec_ff;
   logic [6:0]         min_ff;
   logic               alarm_ff;
   logic [6:0]         delay_min;
   logic               delay_zero;
   logic               expired;

   // ***************************************************
   // delay decode
   // ***************************************************
   // R1: decimal delay in minutes
   // widen before the product, a 4-bit product would lose tens above 1
   assign delay_min  = 7'(set_tens_ff) * 7'h0A + 7'(set_ones_ff);
   // R4: zero disables qualification
   assign delay_zero = (delay_min == 7'h00);
   assign expired    = (min_ff >= delay_min);

   // ***************************************************
   // setup menu
   // ***************************************************
   // R6: menu walk, entering delay submenu
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         menu_ff <= sla_pkg::SLA_NORMAL;
         item_ff <= sla_pkg::MENU_FIRST;
      end else begin
         case (menu_ff)
            sla_pkg::SLA_NORMAL: begin
               if (i_key_setup) begin
                  menu_ff <= sla_pkg::SLA_MENU;
                  item_ff <= sla_pkg::MENU_FIRST;
               end
            end
            sla_pkg::SLA_MENU: begin
               // R8: function key exits menu
               if (i_key_func) begin
                  menu_ff <= sla_pkg::SLA_NORMAL;
               end else if (i_key_enter && item_ff == sla_pkg::MENU_LOCK_ITEM) begin
                  menu_ff <= sla_pkg::SLA_EDIT;
               end else if (i_key_setup) begin
                  // wraps so the walk can repeat
                  item_ff <= item_ff + 2'h1;
               end
            end
            sla_pkg::SLA_EDIT: begin
               // R7: enter returns to menu top
               if (i_key_func) begin
                  menu_ff <= sla_pkg::SLA_NORMAL;
               end else if (i_key_enter) begin
                  menu_ff <= sla_pkg::SLA_MENU;
                  item_ff <= sla_pkg::MENU_FIRST;
               end
            end
            default: begin
               menu_ff <= sla_pkg::SLA_NORMAL;
            end
         endcase
      end
   end

   sla_bcd_step u_step (
      .i_tens (cand_tens_ff),
      .i_ones (cand_ones_ff),
      .i_up   (i_key_up),
      .o_tens (step_tens),
      .o_ones (step_ones)
   );

   // R7: candidate edit and store
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cand_tens_ff <= sla_pkg::DIGIT_RST_TENS;
         cand_ones_ff <= sla_pkg::DIGIT_RST_ONES;
         set_tens_ff  <= sla_pkg::DIGIT_RST_TENS;
         set_ones_ff  <= sla_pkg::DIGIT_RST_ONES;
      end else begin
         if (menu_ff == sla_pkg::SLA_MENU && i_key_enter && !i_key_func
             && item_ff == sla_pkg::MENU_LOCK_ITEM) begin
            // R6: submenu shows current value
            cand_tens_ff <= set_tens_ff;
            cand_ones_ff <= set_ones_ff;
         end else if (menu_ff == sla_pkg::SLA_EDIT && !i_key_func) begin
            if (i_key_enter) begin
               set_tens_ff <= cand_tens_ff;
               set_ones_ff <= cand_ones_ff;
            end else if (i_key_up ^ i_key_down) begin
               cand_tens_ff <= step_tens;
               cand_ones_ff <= step_ones;
            end
         end
      end
   end

   // ***************************************************
   // unlocked time qualification
   // ***************************************************
   // R9: minute count from second tick
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sec_ff <= sla_pkg::SEC_RST;
         min_ff <= sla_pkg::MIN_RST;
      end else if (i_sync_locked) begin
         sec_ff <= sla_pkg::SEC_RST;
         min_ff <= sla_pkg::MIN_RST;
      end else if (i_sec_tick && !alarm_ff && !expired) begin
         if (sec_ff == sla_pkg::SEC_LAST) begin
            sec_ff <= 6'h00;
            min_ff <= min_ff + 7'h01;
         end else begin
            sec_ff <= sec_ff + 6'h01;
         end
      end
   end

   // R2: assert only after full delay
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         alarm_ff <= 1'b0;
      end else begin
         // lowering the delay mid-loss takes effect at once
         alarm_ff <= !i_sync_locked && !delay_zero && expired;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   // R3: relay shares the alarm flop
   assign o_sync_loss_alarm = alarm_ff;
   // R5: fail-safe, energized while locked
   assign o_relay_energize  = !alarm_ff;
   assign o_menu_active     = (menu_ff != sla_pkg::SLA_NORMAL);
   assign o_menu_item       = item_ff;
   assign o_edit_active     = (menu_ff == sla_pkg::SLA_EDIT);
   assign o_disp_tens       = o_edit_active ? cand_tens_ff : set_tens_ff;
   assign o_disp_ones       = o_edit_active ? cand_ones_ff : set_ones_ff;

   // ***************************************************
   // checks
   // ***************************************************
   a_relay_alarm_same: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R3
      o_relay_energize != o_sync_loss_alarm)
      else $error("relay and alarm disagree");
   a_zero_no_alarm: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R4
      delay_zero |=> !o_sync_loss_alarm)
      else $error("alarm with zero delay");
   a_lock_clears: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R2
      i_sync_locked |=> !o_sync_loss_alarm && min_ff == 7'h00)
      else $error("lock did not clear alarm");
   a_rise_needs_time: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R2
      $rose(o_sync_loss_alarm) |-> $past(min_ff) >= $past(delay_min))
      else $error("alarm before delay elapsed");
   a_relay_energized: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R5
      $past(i_sync_locked) |-> o_relay_energize)
      else $error("relay dropped while locked");
   a_minute_step: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R9
      (!i_sync_locked && i_sec_tick && sec_ff == sla_pkg::SEC_LAST && !alarm_ff && !expired)
      |=> min_ff == $past(min_ff) + 7'h01)
      else $error("minute count missed");
   a_count_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R9
      (alarm_ff && !i_sync_locked) |=> $stable(min_ff))
      else $error("count moved after alarm");
   sequence s_open_edit;
      menu_ff == sla_pkg::SLA_MENU && item_ff == sla_pkg::MENU_LOCK_ITEM
         && i_key_enter && !i_key_func;
   endsequence
   a_edit_shows: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R6
      s_open_edit |=> o_edit_active && o_disp_tens == $past(set_tens_ff)
         && o_disp_ones == $past(set_ones_ff))
      else $error("submenu not showing value");
   a_store_return: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R7
      (o_edit_active && i_key_enter && !i_key_func) |=> menu_ff == sla_pkg::SLA_MENU
         && item_ff == sla_pkg::MENU_FIRST && set_ones_ff == $past(cand_ones_ff))
      else $error("enter did not store");
   a_func_exit: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R8
      (o_menu_active && i_key_func) |=> !o_menu_active)
      else $error("function key did not exit");
   a_digit_range: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R1
      set_tens_ff <= sla_pkg::DIGIT_MAX && set_ones_ff <= sla_pkg::DIGIT_MAX)
      else $error("delay digit out of range");
endmodule // sla_top
`default_nettype wire

// >>> rtl/sla_pkg.sv
// sla_pkg: constants for the sync loss delay alarm
package sla_pkg;
   // ***************************************************
   // delay setting and timing
   // ***************************************************
   localparam logic [3:0] DIGIT_MAX      = 4'h9;
   localparam logic [3:0] DIGIT_RST_TENS = 4'h0;
   localparam logic [3:0] DIGIT_RST_ONES = 4'h0;
   localparam int         SEC_PER_MIN    = 60;
   localparam logic [5:0] SEC_LAST       = 6'(SEC_PER_MIN - 1);
   localparam logic [6:0] MIN_RST        = 7'h00;
   localparam logic [5:0] SEC_RST        = 6'h00;
   // ***************************************************
   // setup menu
   // ***************************************************
   localparam int         MENU_ITEMS     = 4;
   localparam logic [1:0] MENU_FIRST     = 2'h0;
   localparam logic [1:0] MENU_LOCK_ITEM = 2'(MENU_ITEMS - 1);
   typedef enum logic [1:0] {
      SLA_NORMAL,
      SLA_MENU,
      SLA_EDIT
   } sla_menu_t;
endpackage : sla_pkg

// >>> rtl/sla_bcd_step.sv
// sla_bcd_step: two-digit decimal up/down stepper with wrap
`timescale 1ns/1ps
`default_nettype none
module sla_bcd_step (
   // current value
   input  wire logic [3:0] i_tens,
   input  wire logic [3:0] i_ones,
   // direction
   input  wire logic       i_up,
   // stepped value
   output logic      [3:0] o_tens,
   output logic      [3:0] o_ones
);
   always_comb begin
      o_tens = i_tens;
      o_ones = i_ones;
      if (i_up) begin
         if (i_ones == sla_pkg::DIGIT_MAX) begin
            o_ones = 4'h0;
            o_tens = (i_tens == sla_pkg::DIGIT_MAX) ? 4'h0 : i_tens + 4'h1;
         end else begin
            o_ones = i_ones + 4'h1;
         end
      end else begin
         if (i_ones == 4'h0) begin
            o_ones = sla_pkg::DIGIT_MAX;
            o_tens = (i_tens == 4'h0) ? sla_pkg::DIGIT_MAX : i_tens - 4'h1;
         end else begin
            o_ones = i_ones - 4'h1;
         end
      end
   end
endmodule // sla_bcd_step
`default_nettype wire

// >>> tb/sla_relay_mon.sv
// sla_relay_mon: model of the equipment watching the alarm relay contacts
`timescale 1ns/1ps
`default_nettype none
module sla_relay_mon (
   // relay coil drive
   input  wire logic i_relay_energize,
   // contact view
   output logic      o_no_closed,
   output logic      o_nc_closed
);
   assign o_no_closed = i_relay_energize;
   assign o_nc_closed = !i_relay_energize;
endmodule // sla_relay_mon
`default_nettype wire

// >>> tb/sla_top_tb_top.sv
// sla_top_tb_top: scenario bench for the sync loss delay alarm
`timescale 1ns/1ps
`default_nettype none
module sla_top_tb_top;
   localparam int K_SET = 0;
   localparam int K_UP  = 1;
   localparam int K_DN  = 2;
   localparam int K_ENT = 3;
   localparam int K_FN  = 4;
   logic       i_clk      = 1'b0;
   logic       i_rst_b    = 1'b0;
   logic       locked     = 1'b1;
   logic       tick       = 1'b0;
   logic [4:0] keys       = 5'h00;
   logic       alarm, relay, menu, edit, no_c, nc_c;
   logic [1:0] item;
   logic [3:0] tens, ones;
   int         num_errors = 0;
   int         num_checks = 0;
   always #5 i_clk = ~i_clk;
   sla_top i_sla_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sync_locked(locked),
      .i_sec_tick(tick), .i_key_setup(keys[K_SET]), .i_key_up(keys[K_UP]),
      .i_key_down(keys[K_DN]), .i_key_enter(keys[K_ENT]), .i_key_func(keys[K_FN]),
      .o_sync_loss_alarm(alarm), .o_relay_energize(relay), .o_menu_active(menu),
      .o_menu_item(item), .o_edit_active(edit), .o_disp_tens(tens), .o_disp_ones(ones));
   sla_relay_mon i_sla_relay_mon (.i_relay_energize(relay), .o_no_closed(no_c),
      .o_nc_closed(nc_c));
   task automatic check_lvl(string what, logic exp, logic got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_val(string what, logic [7:0] exp, logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // keys are one-cycle pulses; result settles by the next falling edge
   task automatic press(int k);
      @(negedge i_clk) keys[k] = 1'b1;
      @(negedge i_clk) keys[k] = 1'b0;
   endtask
   // ticks every other cycle keep a minute at 120 cycles
   task automatic ticks(int n);
      repeat (n) begin
         @(negedge i_clk) tick = 1'b1;
         @(negedge i_clk) tick = 1'b0;
      end
   endtask
   // relay always the inverse of the alarm
   always @(negedge i_clk) begin
      if (i_rst_b) check_lvl("relay vs alarm", !alarm, relay);
   end
   task automatic open_edit();
      press(K_SET);
      check_lvl("menu", 1'b1, menu);
      check_val("item", 8'h00, {6'h00, item});
      press(K_ENT);
      check_lvl("edit at item 0", 1'b0, edit);
      repeat (3) press(K_SET);
      check_val("item", 8'h03, {6'h00, item});
      press(K_ENT);
      check_lvl("edit", 1'b1, edit);
   endtask
   task automatic scn_reset();
      check_lvl("alarm", 1'b0, alarm);
      check_lvl("n.o. closed", 1'b1, no_c);
      check_lvl("menu", 1'b0, menu);
      check_val("disp", 8'h00, {tens, ones});
   endtask
   task automatic scn_set_delay();
      open_edit();
      check_val("disp current", 8'h00, {tens, ones});
      press(K_DN);
      check_val("disp wrap down", 8'h99, {tens, ones});
      press(K_UP);
      check_val("disp wrap up", 8'h00, {tens, ones});
      repeat (2) press(K_UP);
      press(K_ENT);
      check_lvl("edit after store", 1'b0, edit);
      check_val("item after store", 8'h00, {6'h00, item});
      check_val("disp stored", 8'h02, {tens, ones});
      press(K_FN);
      check_lvl("menu after func", 1'b0, menu);
      press(K_UP);
      check_val("disp up in normal", 8'h02, {tens, ones});
   endtask
   task automatic scn_alarm();
      @(negedge i_clk) locked = 1'b0;
      ticks(60);
      @(negedge i_clk) locked = 1'b1;
      ticks(2);
      @(negedge i_clk) locked = 1'b0;
      ticks(119);
      repeat (2) @(negedge i_clk);
      check_lvl("alarm early", 1'b0, alarm);
      ticks(1);
      @(negedge i_clk);
      check_lvl("alarm due", 1'b1, alarm);
      check_lvl("n.c. closed", 1'b1, nc_c);
      ticks(70);
      check_lvl("alarm held", 1'b1, alarm);
      @(negedge i_clk) locked = 1'b1;
      repeat (2) @(negedge i_clk);
      check_lvl("alarm cleared", 1'b0, alarm);
      check_lvl("n.o. closed", 1'b1, no_c);
   endtask
   task automatic scn_zero();
      open_edit();
      repeat (2) press(K_DN);
      press(K_ENT);
      press(K_FN);
      check_val("disp zero", 8'h00, {tens, ones});
      @(negedge i_clk) locked = 1'b0;
      ticks(130);
      repeat (2) @(negedge i_clk);
      check_lvl("alarm disabled", 1'b0, alarm);
   endtask
   // tens digit carries into the minute count; edit exit by func discards
   task automatic scn_tens();
      @(negedge i_clk) locked = 1'b1;
      open_edit();
      repeat (9) press(K_UP);
      check_val("disp before carry", 8'h09, {tens, ones});
      press(K_UP);
      check_val("disp carry", 8'h10, {tens, ones});
      repeat (10) press(K_UP);
      @(negedge i_clk) keys = 5'h06;
      @(negedge i_clk) keys = 5'h00;
      check_val("disp up and down", 8'h20, {tens, ones});
      press(K_ENT);
      press(K_FN);
      open_edit();
      check_val("disp current twenty", 8'h20, {tens, ones});
      press(K_UP);
      press(K_FN);
      check_lvl("menu after func in edit", 1'b0, menu);
      check_val("disp kept", 8'h20, {tens, ones});
      @(negedge i_clk) locked = 1'b0;
      ticks(1199);
      repeat (2) @(negedge i_clk);
      check_lvl("alarm before twenty", 1'b0, alarm);
      ticks(1);
      @(negedge i_clk);
      check_lvl("alarm at twenty", 1'b1, alarm);
      check_lvl("n.c. closed at twenty", 1'b1, nc_c);
   endtask
   // limit sits far above the few thousand cycles the run needs
   initial begin
      #100000;
      num_errors++;
      give_verdict();
   end
   initial begin
      repeat (5) @(negedge i_clk);
      i_rst_b = 1'b1;
      scn_reset();
      scn_set_delay();
      scn_alarm();
      scn_zero();
      scn_tens();
      give_verdict();
   end
endmodule // sla_top_tb_top
`default_nettype wire
